// File: inc/hbu_pkg.sv
// Purpose: shared constants and types of the host bus unit
// Assumes: 10-bit byte address space, 32-bit internal data words
// Notes:   status FIFO addresses are plain defaults of this design
package hbu_pkg;
    localparam int         ADDR_W      = 10;
    localparam int         SYNC_W      = 29;
    localparam int         EVT_W       = 8;
    // dword addresses of the status FIFO windows
    localparam logic [7:0] RX_STS_DW   = 8'h10;
    localparam logic [7:0] RX_PEEK_DW  = 8'h11;
    localparam logic [7:0] TX_STS_DW   = 8'h12;
    localparam logic [7:0] TX_PEEK_DW  = 8'h13;
    // dual phase bit positions on the address/data pins
    localparam int         DP8_BIG     = 2;
    localparam int         DP8_FIFO    = 3;
    localparam int         DP16_BIG    = 1;
    localparam int         DP16_FIFO   = 2;
    // single phase bit positions, one and two above the top address bit
    localparam int         SP8_BIG     = 10;
    localparam int         SP8_FIFO    = 11;
    localparam int         SP16_BIG    = 9;
    localparam int         SP16_FIFO   = 10;
    // last part index of a dword: 8-bit and 16-bit bus
    localparam logic [1:0] LAST_8      = 2'h3;
    localparam logic [1:0] LAST_16     = 2'h1;
    localparam logic [1:0] CNT_RST     = 2'h0;
    localparam logic [9:0] ADDR_RST    = 10'h000;
    localparam logic [31:0] DW_RST     = 32'h0000_0000;
    localparam logic [15:0] OE_OFF     = 16'hFFFF;

    // latched address state
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              big;
        logic              fifo;
    } hbu_lat_t;

    // one assembled internal write
    typedef struct packed {
        logic              to_tx;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
    } hbu_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_REQ   = 2'b01,
        ST_SERVE = 2'b10
    } hbu_st_t;
endpackage : hbu_pkg

// File: rtl/hbu_buf2.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   in_ready_o is low only when both entries are taken
`timescale 1ns/1ps
module hbu_buf2 #(
    parameter int W = 43
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    logic [W-1:0] slot0, slot1, next_slot0, next_slot1;
    logic [1:0]   cnt, next_cnt;
    logic         push, pop;

    // slot0 is always the head, so the output comes straight from a flop
    always_comb begin
        push       = in_valid_i && (cnt != 2'h2);
        pop        = (cnt != 2'h0) && out_ready_i;
        next_slot0 = slot0;
        next_slot1 = slot1;
        next_cnt   = cnt;
        if (pop) begin
            next_slot0 = slot1;
        end
        if (push) begin
            if ((cnt == 2'h0) || ((cnt == 2'h1) && pop)) begin
                next_slot0 = in_data_i;
            end else begin
                next_slot1 = in_data_i;
            end
        end
        next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt   <= 2'h0;
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            cnt   <= next_cnt;
            slot0 <= next_slot0;
            slot1 <= next_slot1;
        end
    end

    assign in_ready_o  = (cnt != 2'h2);
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o  = slot0;
endmodule : hbu_buf2

// File: rtl/hbu_lane.sv
// Purpose: byte lane steering between host bus and little-endian dword
// Assumes: lane_i is the latched byte address low bits
// Notes:   big endian mirrors byte i of the dword to host byte 3-i
`timescale 1ns/1ps
module hbu_lane (
    input  wire logic [31:0] rdw_i,
    input  wire logic [31:0] wdw_i,
    input  wire logic [15:0] hdata_i,
    input  wire logic [1:0]  lane_i,
    input  wire logic        big_i,
    input  wire logic        bus16_i,
    output logic [15:0]      rd_o,
    output logic [31:0]      merged_o
);
    logic [1:0] idx [2];

    // host byte h of this access lands on dword byte idx[h]
    for (genvar h = 0; h < 2; h++) begin : g_host
        logic [1:0] lin;
        assign lin = bus16_i ? {lane_i[1], 1'(h)} : lane_i;
        assign idx[h] = big_i ? 2'(2'h3 - lin) : lin;
        if (h == 0) begin : g_lo
            assign rd_o[7:0] = rdw_i[8*idx[0] +: 8];
        end else begin : g_hi
            // the upper lane carries nothing on an 8-bit bus
            assign rd_o[15:8] = bus16_i ? rdw_i[8*idx[1] +: 8] : 8'h00;
        end
    end

    // each dword byte takes the host byte that maps onto it
    for (genvar b = 0; b < 4; b++) begin : g_byte
        assign merged_o[8*b +: 8] = (idx[0] == 2'(b)) ? hdata_i[7:0] :
                                    (bus16_i && (idx[1] == 2'(b))) ? hdata_i[15:8] :
                                    wdw_i[8*b +: 8];
    end
endmodule : hbu_lane

// File: rtl/hbu_host_port.sv
// Purpose: multiplexed address/data host port with dword assembly
// Assumes: every pin is asynchronous and passes two flops first
// Notes:   the register core answers reg_rd_data_i while reg_rd_req_o is high
`timescale 1ns/1ps
module hbu_host_port #(
    parameter int EVT_W = hbu_pkg::EVT_W
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [15:0]      ad_i,
    output logic [15:0]           ad_o,
    output logic [15:0]           ad_oe_n_o,
    input  wire logic             low_address_strobe_i,
    input  wire logic             high_address_strobe_i,
    input  wire logic             cs_i,
    input  wire logic             rd_line_i,
    input  wire logic             transfer_enable_strobe_i,
    input  wire logic             strobe_polarity_cfg_i,
    input  wire logic             select_polarity_cfg_i,
    input  wire logic             read_line_polarity_cfg_i,
    input  wire logic             write_line_polarity_cfg_i,
    input  wire logic             signalling_scheme_cfg_i,
    input  wire logic             strobe_gating_cfg_i,
    input  wire logic             bus16_cfg_i,
    input  wire logic             dual_phase_cfg_i,
    output logic                  reg_rd_req_o,
    output logic [9:0]            reg_rd_addr_o,
    input  wire logic [31:0]      reg_rd_data_i,
    input  wire logic             reg_single_i,
    output logic                  reg_rd_done_o,
    output logic                  hold_o,
    output logic                  tx_sts_pop_o,
    output logic                  rx_sts_pop_o,
    input  wire logic [31:0]      rx_fifo_data_i,
    output logic                  rx_fifo_pop_o,
    output logic                  wr_valid_o,
    input  wire logic             wr_ready_i,
    output hbu_pkg::hbu_wr_t      wr_o,
    input  wire logic [EVT_W-1:0] hw_evt_i,
    output logic [EVT_W-1:0]      live_evt_o
);
    logic [hbu_pkg::SYNC_W-1:0] meta, syn;
    logic [15:0]       ad_s, ad_q, lane_rd;
    logic              lo_act, hi_act, cs_act, rdl_act, enl_act, rd_act, wr_act;
    logic              s_pol_ale, s_pol_cs, s_pol_rd, s_pol_wr, s_scheme, s_gate;
    logic              bus16, s_dual;
    logic              prev_lo, prev_hi, prev_cs, prev_wr;
    logic              lo_fall, hi_fall, qual_ok, wr_fall;
    hbu_pkg::hbu_lat_t lat, next_lat;
    hbu_pkg::hbu_st_t  st, next_st;
    logic [1:0]        rcnt, next_rcnt, wcnt, next_wcnt, last_idx;
    logic [31:0]       dw, next_dw, asm_dw, next_asm, merged;
    logic [7:0]        seq, next_seq;
    logic              seq_fifo, next_seq_fifo, single, next_single;
    logic              next_done, next_txp, next_rxp, next_rxf;
    logic [15:0]       next_ad, next_oe;
    logic              wpend, next_wpend, rd_seen, next_rd_seen, buf_ready;
    hbu_pkg::hbu_wr_t  wword, next_wword;
    logic [EVT_W-1:0]  evt_pend, next_evt_pend, next_live;
    logic              fresh, last_rd;

    // two flops on every pin; only the second stage is read below
    // no reset: cleared stages would make low-active lines look active, faking edges
    always_ff @(posedge mclk_i) begin
        meta <= {ad_i, dual_phase_cfg_i, bus16_cfg_i, strobe_gating_cfg_i,
                 signalling_scheme_cfg_i, write_line_polarity_cfg_i,
                 read_line_polarity_cfg_i, select_polarity_cfg_i,
                 strobe_polarity_cfg_i, transfer_enable_strobe_i, rd_line_i,
                 cs_i, high_address_strobe_i, low_address_strobe_i};
        syn  <= meta;
    end

    // line levels turned to active levels by the polarity straps
    always_comb begin
        {ad_s, s_dual, bus16, s_gate, s_scheme, s_pol_wr, s_pol_rd, s_pol_cs,
         s_pol_ale} = syn[28:5];
        lo_act  = syn[0] ~^ s_pol_ale;
        hi_act  = syn[1] ~^ s_pol_ale;
        cs_act  = syn[2] ~^ s_pol_cs;
        rdl_act = syn[3] ~^ s_pol_rd;
        enl_act = syn[4] ~^ s_pol_wr;
        // direction line at its active level means write
        rd_act  = s_scheme ? (cs_act && enl_act && !rdl_act) : (cs_act && rdl_act);
        wr_act  = s_scheme ? (cs_act && enl_act && rdl_act) : (cs_act && enl_act);
        lo_fall = prev_lo && !lo_act;
        hi_fall = prev_hi && !hi_act;
        wr_fall = prev_wr && !wr_act;
        qual_ok = !s_gate || prev_cs;
        last_idx = bus16 ? hbu_pkg::LAST_16 : hbu_pkg::LAST_8;
    end

    // address latch: trailing strobe edge takes the pins of the cycle before
    always_comb begin
        next_lat = lat;
        if (lo_fall && qual_ok) begin
            if (s_dual) begin
                if (bus16) begin
                    next_lat.addr[8:1] = ad_q[7:0];
                end else begin
                    next_lat.addr[7:0] = ad_q[7:0];
                end
            end else if (bus16) begin
                next_lat.addr[9:1] = ad_q[8:0];
                next_lat.big       = ad_q[hbu_pkg::SP16_BIG];
                next_lat.fifo      = ad_q[hbu_pkg::SP16_FIFO];
            end else begin
                next_lat.addr = ad_q[9:0];
                next_lat.big  = ad_q[hbu_pkg::SP8_BIG];
                next_lat.fifo = ad_q[hbu_pkg::SP8_FIFO];
            end
        end
        // high phase only in dual mode; either order, either skippable
        if (hi_fall && qual_ok && s_dual) begin
            if (bus16) begin
                next_lat.addr[9] = ad_q[0];
                next_lat.big     = ad_q[hbu_pkg::DP16_BIG];
                next_lat.fifo    = ad_q[hbu_pkg::DP16_FIFO];
            end else begin
                next_lat.addr[9:8] = ad_q[1:0];
                next_lat.big       = ad_q[hbu_pkg::DP8_BIG];
                next_lat.fifo      = ad_q[hbu_pkg::DP8_FIFO];
            end
        end
        if (bus16) begin
            next_lat.addr[0] = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lat     <= '{addr: hbu_pkg::ADDR_RST, big: 1'b0, fifo: 1'b0};
            prev_lo <= 1'b0;
            prev_hi <= 1'b0;
            prev_cs <= 1'b0;
            prev_wr <= 1'b0;
            ad_q    <= 16'h0000;
        end else begin
            lat     <= next_lat;
            prev_lo <= lo_act;
            prev_hi <= hi_act;
            prev_cs <= cs_act;
            prev_wr <= wr_act;
            ad_q    <= ad_s;
        end
    end

    // byte steering by latched endian, low address bits and the bus width strap
    hbu_lane u_lane (
        .rdw_i    (dw),
        .wdw_i    (asm_dw),
        .hdata_i  (ad_q),
        .lane_i   (lat.addr[1:0]),
        .big_i    (lat.big),
        .bus16_i  (bus16),
        .rd_o     (lane_rd),
        .merged_o (merged)
    );

    // access engine: read fetch/serve and write assembly
    always_comb begin
        next_st       = st;
        next_rcnt     = rcnt;
        next_wcnt     = wcnt;
        next_dw       = dw;
        next_asm      = asm_dw;
        next_seq      = seq;
        next_seq_fifo = seq_fifo;
        next_single   = single;
        next_done     = 1'b0;
        next_txp      = 1'b0;
        next_rxp      = 1'b0;
        next_rxf      = 1'b0;
        next_ad       = ad_o;
        next_oe       = hbu_pkg::OE_OFF;
        next_rd_seen  = rd_seen;
        next_wword    = wword;
        next_wpend    = wpend && !buf_ready;
        // a new dword starts unless this read continues the locked one
        fresh   = (rcnt == hbu_pkg::CNT_RST) || (lat.fifo != seq_fifo) ||
                  (!lat.fifo && (lat.addr[9:2] != seq));
        last_rd = single || (rcnt == last_idx);
        unique case (st)
            hbu_pkg::ST_IDLE: begin
                if (rd_act) begin
                    if (fresh) begin
                        next_rcnt     = hbu_pkg::CNT_RST;
                        next_seq      = lat.addr[9:2];
                        next_seq_fifo = lat.fifo;
                        next_st       = hbu_pkg::ST_REQ;
                    end else begin
                        next_st = hbu_pkg::ST_SERVE;
                    end
                end
            end
            hbu_pkg::ST_REQ: begin
                // dword snapshot taken once at the start of the sequence
                next_dw     = seq_fifo ? rx_fifo_data_i : reg_rd_data_i;
                next_single = reg_single_i && !seq_fifo;
                next_st     = hbu_pkg::ST_SERVE;
            end
            hbu_pkg::ST_SERVE: begin
                if (rd_act) begin
                    next_ad = lane_rd;
                    next_oe = bus16 ? 16'h0000 : 16'hFF00;
                end else begin
                    next_st      = hbu_pkg::ST_IDLE;
                    next_rd_seen = 1'b1;
                    if (last_rd) begin
                        next_rcnt = hbu_pkg::CNT_RST;
                        next_done = 1'b1;
                        next_rxf  = seq_fifo;
                        next_txp  = !seq_fifo && (seq == hbu_pkg::TX_STS_DW);
                        next_rxp  = !seq_fifo && (seq == hbu_pkg::RX_STS_DW);
                    end else begin
                        next_rcnt = 2'(rcnt + 2'h1);
                    end
                end
            end
            default: begin
                next_st = hbu_pkg::ST_IDLE;
            end
        endcase
        // writes are dropped until the first read and while one waits
        if (wr_fall && rd_seen && !wpend) begin
            if (wcnt == last_idx) begin
                next_wcnt  = hbu_pkg::CNT_RST;
                next_asm   = hbu_pkg::DW_RST;
                next_wpend = 1'b1;
                next_wword = '{to_tx: lat.fifo, addr: {lat.addr[9:2], 2'h0},
                               data: merged};
            end else begin
                next_wcnt = 2'(wcnt + 2'h1);
                next_asm  = merged;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st            <= hbu_pkg::ST_IDLE;
            rcnt          <= hbu_pkg::CNT_RST;
            wcnt          <= hbu_pkg::CNT_RST;
            dw            <= hbu_pkg::DW_RST;
            asm_dw        <= hbu_pkg::DW_RST;
            seq           <= 8'h00;
            seq_fifo      <= 1'b0;
            single        <= 1'b0;
            reg_rd_done_o <= 1'b0;
            tx_sts_pop_o  <= 1'b0;
            rx_sts_pop_o  <= 1'b0;
            rx_fifo_pop_o <= 1'b0;
            ad_o          <= 16'h0000;
            ad_oe_n_o     <= hbu_pkg::OE_OFF;
            rd_seen       <= 1'b0;
            wpend         <= 1'b0;
            wword         <= '0;
        end else begin
            st            <= next_st;
            rcnt          <= next_rcnt;
            wcnt          <= next_wcnt;
            dw            <= next_dw;
            asm_dw        <= next_asm;
            seq           <= next_seq;
            seq_fifo      <= next_seq_fifo;
            single        <= next_single;
            reg_rd_done_o <= next_done;
            tx_sts_pop_o  <= next_txp;
            rx_sts_pop_o  <= next_rxp;
            rx_fifo_pop_o <= next_rxf;
            ad_o          <= next_ad;
            ad_oe_n_o     <= next_oe;
            rd_seen       <= next_rd_seen;
            wpend         <= next_wpend;
            wword         <= next_wword;
        end
    end

    assign reg_rd_req_o  = (st == hbu_pkg::ST_REQ);
    assign reg_rd_addr_o = {seq, 2'h0};
    assign hold_o        = (st != hbu_pkg::ST_IDLE) || (rcnt != hbu_pkg::CNT_RST);

    // the buffer absorbs receiver stalls; wpend holds a third word
    hbu_buf2 #(
        .W ($bits(hbu_pkg::hbu_wr_t))
    ) u_buf (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (wpend),
        .in_ready_o  (buf_ready),
        .in_data_i   (wword),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_o)
    );

    // hardware events seen during a hold are parked, then released
    always_comb begin
        next_evt_pend = hold_o ? (evt_pend | hw_evt_i) : '0;
        next_live     = hold_o ? '0 : (evt_pend | hw_evt_i);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            evt_pend   <= '0;
            live_evt_o <= '0;
        end else begin
            evt_pend   <= next_evt_pend;
            live_evt_o <= next_live;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    req_hold_a: assert property (reg_rd_req_o |-> hold_o ##1 (st == hbu_pkg::ST_SERVE))
        else $error("read request without hold");
    evt_defer_a: assert property (hold_o |=> live_evt_o == '0)
        else $error("event applied during hold");
    evt_release_a: assert property ($fell(hold_o) && evt_pend != '0 |=> live_evt_o != '0)
        else $error("deferred event lost");
    single_done_a: assert property (st == hbu_pkg::ST_SERVE && single && !rd_act
                                    |=> reg_rd_done_o && rcnt == 2'h0)
        else $error("pollable read did not complete");
    sts_pop_a: assert property (st == hbu_pkg::ST_SERVE && !rd_act && last_rd && !seq_fifo
                                && seq == hbu_pkg::TX_STS_DW |=> tx_sts_pop_o)
        else $error("status read did not pop");
    peek_nopop_a: assert property (reg_rd_done_o && (seq == hbu_pkg::TX_PEEK_DW ||
                                   seq == hbu_pkg::RX_PEEK_DW) |-> !tx_sts_pop_o && !rx_sts_pop_o)
        else $error("peek read popped");
    direct_tx_a: assert property ($rose(wpend) |-> wword.to_tx == $past(lat.fifo))
        else $error("write steered wrongly");
    addr_keep_a: assert property (!lo_fall && !hi_fall |=> lat == $past(lat))
        else $error("latched address changed without strobe");
    word_addr_a: assert property (bus16 && lo_fall && qual_ok && !s_dual
                                  |=> lat.addr == {$past(ad_q[8:0]), 1'b0})
        else $error("word address not converted");
    narrow_lane_a: assert property (!bus16 |-> ad_oe_n_o[15:8] == 8'hFF)
        else $error("upper lane driven on 8-bit bus");
    wr_count_a: assert property (wr_fall && rd_seen && !wpend && wcnt != last_idx
                                 |=> wcnt == 2'($past(wcnt) + 2'h1) && !$rose(wpend))
        else $error("write counter did not advance");

    full_read_c: cover property (reg_rd_done_o && !single);
    direct_wr_c: cover property ($rose(wpend) && wword.to_tx);
    stall_c: cover property (wpend && !buf_ready);
endmodule : hbu_host_port

// File: sim/hbu_host_model.sv
// Purpose: host processor model for the multiplexed address/data pins
// Assumes: lines ordered address strobe, select, read, write; pol_i sets active levels
// Notes:   released pins toggle each cycle so a stale value never matches
`timescale 1ns/1ps
module hbu_host_model (
    input  wire logic        mclk_i,
    input  wire logic [3:0]  pol_i,
    input  wire logic        sch_i,
    input  wire logic [15:0] rd_i,
    output logic [15:0]      ad_o,
    output logic [3:0]       ln_o
);
    logic [3:0]  act = 4'h0;
    logic        drv = 1'b0;
    logic [15:0] dat = 16'h0000;
    logic [15:0] pat = 16'h5A5A;
    // control lines at their strapped active level
    assign ln_o = act ~^ pol_i;
    // an undriven bus shows a pattern that inverts every cycle
    always @(posedge mclk_i) pat <= #1 ~pat;
    assign ad_o = drv ? dat : pat;
    // one whole bus cycle; the pins are released before the next one starts
    task automatic cyc(input logic [3:0] a, input logic [15:0] d, input int n,
                       output logic [15:0] q);
        @(posedge mclk_i) #1;
        // the host drives the pins for an address phase or a write only
        drv = a[3] | (a[0] & (sch_i ? a[1] : 1'b1));
        dat = d;
        act = a;
        repeat (n) @(posedge mclk_i);
        q = rd_i;
        #1 act = 4'h0;
        repeat (4) @(posedge mclk_i);
        #1 drv = 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : cyc
endmodule : hbu_host_model

// File: sim/tb_top.sv
// Purpose: self-checking bench of the host bus unit
// Assumes: 16-bit single phase latching, both signalling schemes, random polarities
// Notes:   status and fifo pulses are tallied per scenario
`timescale 1ns/1ps
module tb_top;
    logic             mclk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic             wr_ready_i = 1'b0;
    logic [3:0]       pol = 4'h0, ln;
    logic [15:0]      ad_i, ad_o, ad_oe_n_o, q;
    logic [9:0]       reg_rd_addr_o;
    logic [31:0]      rx_head = 32'h1357_9BDF;
    logic [7:0]       hw_evt = 8'h00, live, ev_pk = 8'h00, ev_ex = 8'h00;
    logic             done, hold, tx_pop, rx_pop, fpop, req, wr_valid_o;
    logic             sch = 1'b0, sgl = 1'b0;
    hbu_pkg::hbu_wr_t wr_o, wr_got;
    int               n_mismatch = 0, checks_done = 0, n_rx = 0, n_tx = 0, n_fp = 0;
    int               n_dn = 0, n_wr = 0;
    function automatic logic [31:0] f_dw(input logic [9:0] a);
        return {a[7:0], ~a[7:0], 6'h15, a};
    endfunction : f_dw
    // big endian mirrors the byte order of the whole dword
    function automatic logic [31:0] f_bs(input logic [31:0] d, input logic big);
        return big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction : f_bs
    hbu_host_port u_hbu_host_port (.mclk_i, .sys_rst_i, .ad_i, .ad_o, .ad_oe_n_o,
        .low_address_strobe_i(ln[3]), .high_address_strobe_i(ln[3]), .cs_i(ln[2]),
        .rd_line_i(ln[1]), .transfer_enable_strobe_i(ln[0]), .strobe_polarity_cfg_i(pol[3]),
        .select_polarity_cfg_i(pol[2]), .read_line_polarity_cfg_i(pol[1]),
        .write_line_polarity_cfg_i(pol[0]), .signalling_scheme_cfg_i(sch),
        .strobe_gating_cfg_i(1'b0), .bus16_cfg_i(1'b1), .dual_phase_cfg_i(1'b0),
        .reg_rd_req_o(req), .reg_rd_addr_o, .reg_rd_data_i(f_dw(reg_rd_addr_o)),
        .reg_single_i(sgl), .reg_rd_done_o(done), .hold_o(hold), .tx_sts_pop_o(tx_pop),
        .rx_sts_pop_o(rx_pop), .rx_fifo_data_i(rx_head), .rx_fifo_pop_o(fpop),
        .wr_valid_o, .wr_ready_i, .wr_o, .hw_evt_i(hw_evt), .live_evt_o(live));
    // read data only counts on lanes the design enables
    hbu_host_model u_hbu_host_model (.mclk_i, .pol_i(pol), .sch_i(sch),
        .rd_i(ad_o & ~ad_oe_n_o), .ad_o(ad_i), .ln_o(ln));
    initial forever #10 mclk_i = ~mclk_i;
    // receiver stalls at random; pop pulses are tallied
    always @(posedge mclk_i) begin
        wr_ready_i <= #1 1'($urandom);
        hw_evt <= #1 8'($urandom);
        n_rx += int'(rx_pop);
        n_tx += int'(tx_pop);
        n_fp += int'(fpop);
        if (fpop === 1'b1) rx_head <= #1 rx_head + 32'h2468_ACE1;
        n_dn += int'(done);
        // accepted words are caught here; a short stall may end before a task looks
        if (wr_valid_o === 1'b1 && wr_ready_i) begin
            wr_got = wr_o;
            n_wr++;
        end
        // events met during a hold come out one cycle after it ends
        if (!sys_rst_i) chk_rd(16'(live), 16'(ev_ex));
        ev_ex <= (sys_rst_i || hold) ? 8'h00 : (ev_pk | hw_evt);
        ev_pk <= (sys_rst_i || !hold) ? 8'h00 : (ev_pk | hw_evt);
    end
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic chk_wr(input hbu_pkg::hbu_wr_t got, input hbu_pkg::hbu_wr_t exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_wr
    task automatic wrap_up;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // both words of one dword, or only the first when sgl is set, relatching the low address for each
    task automatic rd_dw(input logic [9:0] a, input logic big, fifo, input logic [31:0] dw);
        for (int h = 0; h < (sgl ? 1 : 2); h++) begin
            u_hbu_host_model.cyc(4'h8, {5'h00, fifo, big, a[9:2], h[0]}, 3, q);
            u_hbu_host_model.cyc(sch ? 4'h5 : 4'h6, 16'h0000, 8, q);
            chk_rd(q, 16'(f_bs(dw, big) >> (16 * h)));
            chk_rd(ad_oe_n_o, 16'hFFFF);
        end
    endtask : rd_dw
    task automatic wr_dw(input logic [9:0] a, input logic big, fifo, input logic [31:0] hd);
        int i = 0;
        int w0 = n_wr;
        hbu_pkg::hbu_wr_t got;
        for (int h = 0; h < 2; h++) begin
            u_hbu_host_model.cyc(4'h8, {5'h00, fifo, big, a[9:2], h[0]}, 3, q);
            u_hbu_host_model.cyc(sch ? 4'h7 : 4'h5, 16'(hd >> (16 * h)), 4, q);
        end
        while (n_wr == w0 && i < 300) begin
            @(negedge mclk_i);
            i++;
        end
        if (n_wr == w0) begin
            n_mismatch++;
            wrap_up();
        end
        got = wr_got;
        if (fifo) got.addr = 10'h000; // the fifo window ignores the address
        chk_wr(got, {fifo, fifo ? 10'h000 : {a[9:2], 2'b00}, f_bs(hd, big)});
    endtask : wr_dw
    initial begin
        logic [9:0]  a;
        logic [31:0] h0;
        void'($urandom(38));
        pol = 4'($urandom);
        repeat (5) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        for (int k = 0; k < 6; k++) begin
            sch = k[2];
            a = {1'b1, 7'($urandom), 2'b00};
            rd_dw(a, k[0], 1'b0, f_dw(a));
            wr_dw(a, k[1], 1'b0, $urandom);
        end
        // status windows: only the plain addresses pop
        for (int s = 0; s < 4; s++) begin
            a = {hbu_pkg::RX_STS_DW + 8'(s), 2'b00};
            n_rx = 0;
            n_tx = 0;
            n_dn = 0;
            rd_dw(a, 1'b0, 1'b0, f_dw(a));
            chk_rd(16'(n_rx), {15'h0000, s == 0});
            chk_rd(16'(n_tx), {15'h0000, s == 2});
            chk_rd(16'(n_dn), 16'h0001);
        end
        // pollable register: one word ends the sequence and may be read again
        sgl = 1'b1;
        n_dn = 0;
        rd_dw(a, 1'b0, 1'b0, f_dw(a));
        rd_dw(a, 1'b1, 1'b0, f_dw(a));
        chk_rd(16'(n_dn), 16'h0002);
        sgl = 1'b0;
        // fifo direct: any address reads the rx head, writes go to tx
        h0 = rx_head;
        n_fp = 0;
        rd_dw(10'($urandom), 1'b1, 1'b1, h0);
        chk_rd(16'(n_fp), 16'h0001);
        wr_dw(10'($urandom), 1'b0, 1'b1, $urandom);
        wrap_up();
    end
    initial begin
        #1_000_000;
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_top
